// ===== rtl/ctd_top.sv
// composite timer data-register path: two channels behind an apb slave
//
// The APB register port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none

module ctd_channel import ctd_pkg::*; (
   input  wire logic       sys_clk,    // system clock
   input  wire logic       nrst,       // async reset, active low
   input  wire logic       runLo,      // lower timer run bit
   input  wire logic       runHi,      // upper timer run bit
   input  wire logic       cascadeSel, // join timers into 16 bits
   input  wire logic [3:0] funcSel,    // function select code
   input  wire logic       measPin,    // measured input pin, asynchronous
   input  wire logic       rdUpper,    // read pulse, upper data register
   input  wire logic       rdLower,    // read pulse, lower data register
   input  wire logic       wrUpper,    // write pulse, upper data register
   input  wire logic       wrLower,    // write pulse, lower data register
   input  wire logic [7:0] wrData,     // write data
   output logic      [7:0] upperVal,   // value an upper read returns
   output logic      [7:0] lowerVal,   // value a lower read returns
   output logic            bufFull,    // lower timer buffer full
   output logic      [1:0] timerOut    // timer outputs, from flops
);

   typedef struct packed {
      logic [1:0][7:0] cnt;
      logic [1:0][7:0] lat;
      logic [1:0][7:0] dat;
      logic [1:0]      bf;
      logic [1:0]      tout;
      logic [1:0]      arm;
      logic [1:0]      runPrev;
      logic [7:0]      wbuf;
      logic [7:0]      rbuf;
      logic            sync1;
      logic            sync2;
      logic            inPrev;
   } ctd_chan_t;

   ctd_chan_t  s_q;
   ctd_chan_t  s_d;
   ctd_unit_t  u;
   ctd_unit_t  uo;
   logic       varMode;
   logic       wide;
   logic       buffered;
   logic       measMode;
   logic       rise;
   logic       fall;
   logic       start0;
   logic [1:0] startN;
   logic [7:0] lowerShow;

   // ------------------------------------------------------------
   // one timer step, 8 or 16 bits wide depending on top
   // ------------------------------------------------------------
   function automatic ctd_unit_t unitStep(input ctd_unit_t ui, input logic [15:0] top,
                                          input logic run, input logic start,
                                          input logic [3:0] mode, input logic lvl,
                                          input logic rs, input logic fl);
      ctd_unit_t   r;
      logic [15:0] nxt;
      r = ui;
      nxt = (ui.cnt == top) ? 16'h0000 : ui.cnt + 16'h0001;
      if (start) begin
         r.lat = ui.dat;
         r.cnt = 16'h0000;
         r.arm = 1'b0;
         if (mode == MODE_PWM_FIX) begin
            r.out = 1'b1;
         end
      end else if (run) begin
         case (mode)
            MODE_INTERVAL: begin
               if (ui.cnt == ui.lat) begin
                  r.lat = ui.dat;
                  r.cnt = 16'h0000;
                  r.out = ~ui.out;
               end else begin
                  r.cnt = nxt;
               end
            end
            MODE_PWM_FIX: begin
               if (ui.cnt == ui.lat) begin
                  r.out = 1'b0;
               end
               if (ui.cnt == top) begin
                  r.lat = ui.dat;
                  r.cnt = 16'h0000;
                  r.out = 1'b1;
               end else begin
                  r.cnt = nxt;
               end
            end
            MODE_PWC_HIGH: begin
               if (rs) begin
                  r.cnt = 16'h0000;
               end else if (lvl && ui.cnt != top) begin
                  r.cnt = nxt;
               end
               if (fl && !ui.bf) begin
                  r.dat = ui.cnt;
                  r.bf  = 1'b1;
               end
            end
            MODE_PWC_HC: begin
               r.cnt = rs ? 16'h0000 : nxt;
               if (fl) begin
                  r.dat = ui.cnt;
                  r.bf  = 1'b1;
               end
               if (rs) begin
                  r.arm = 1'b1;
                  if (ui.arm && !ui.bf) begin
                     r.dat = ui.cnt;
                     r.bf  = 1'b1;
                  end
               end
            end
            MODE_CAPTURE: begin
               r.cnt = nxt;
               if (rs) begin
                  r.dat = ui.cnt;
               end
            end
            default: begin
               r = ui;
            end
         endcase
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // mode decode and input edges
   // ------------------------------------------------------------
   assign varMode  = (funcSel == MODE_PWM_VAR);
   assign wide     = cascadeSel & ~varMode;
   assign buffered = cascadeSel | varMode;
   assign measMode = (funcSel == MODE_PWC_HIGH) | (funcSel == MODE_PWC_HC) |
                     (funcSel == MODE_CAPTURE);
   assign rise     = s_q.sync2 & ~s_q.inPrev;
   assign fall     = ~s_q.sync2 & s_q.inPrev;
   assign startN   = {runHi, runLo} & ~s_q.runPrev;
   assign start0   = startN[0];
   assign lowerShow = measMode ? s_q.dat[0] : s_q.cnt[0];

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      u = '0;
      uo = '0;
      s_d.sync1 = measPin;
      s_d.sync2 = s_q.sync1;
      s_d.inPrev = s_q.sync2;
      s_d.runPrev = {runHi, runLo};
      // clear before the step so a result landing in the same cycle wins
      if (rdLower) begin
         s_d.bf[0] = 1'b0;
      end
      if (rdUpper && !buffered) begin
         s_d.bf[1] = 1'b0;
      end
      if (rdUpper && buffered) begin
         s_d.rbuf = lowerShow;
      end
      if (varMode) begin
         if (start0) begin
            s_d.lat = s_q.dat;
            s_d.cnt = '0;
            s_d.tout[0] = 1'b0;
         end else if (runLo) begin
            if (s_q.cnt[0] == s_q.lat[0]) begin
               s_d.tout[0] = 1'b1;
            end else begin
               s_d.cnt[0] = s_q.cnt[0] + 8'h01;
            end
            if (s_q.cnt[1] == s_q.lat[1]) begin
               s_d.lat = s_q.dat;
               s_d.cnt = '0;
               s_d.tout[0] = 1'b0;
            end else begin
               s_d.cnt[1] = s_q.cnt[1] + 8'h01;
            end
         end
      end else if (wide) begin
         u = '{cnt: s_q.cnt, lat: s_q.lat, dat: s_q.dat,
               bf: s_d.bf[0], out: s_q.tout[0], arm: s_q.arm[0]};
         uo = unitStep(u, COUNT_TOP16, runLo, start0, funcSel, s_q.sync2, rise, fall);
         s_d.cnt = uo.cnt;
         s_d.lat = uo.lat;
         s_d.dat = uo.dat;
         s_d.bf[0] = uo.bf;
         s_d.tout[0] = uo.out;
         s_d.arm[0] = uo.arm;
      end else begin
         for (int i = 0; i < 2; i++) begin
            u = '{cnt: {8'h00, s_q.cnt[i]}, lat: {8'h00, s_q.lat[i]},
                  dat: {8'h00, s_q.dat[i]}, bf: s_d.bf[i], out: s_q.tout[i],
                  arm: s_q.arm[i]};
            uo = unitStep(u, COUNT_TOP8, (i == 0) ? runLo : runHi, startN[i], funcSel,
                          s_q.sync2, rise, fall);
            s_d.cnt[i] = uo.cnt[7:0];
            s_d.lat[i] = uo.lat[7:0];
            s_d.dat[i] = uo.dat[7:0];
            s_d.bf[i] = uo.bf;
            s_d.tout[i] = uo.out;
            s_d.arm[i] = uo.arm;
         end
      end
      // software writes come last so they replace any stored result
      if (buffered) begin
         if (wrUpper) begin
            s_d.wbuf = wrData;
         end
         if (wrLower) begin
            s_d.dat[0] = wrData;
            s_d.dat[1] = s_q.wbuf;
         end
      end else begin
         if (wrUpper) begin
            s_d.dat[1] = wrData;
         end
         if (wrLower) begin
            s_d.dat[0] = wrData;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         s_q <= '{cnt: '0, lat: '0, dat: {DATA_RST, DATA_RST}, bf: 2'h0, tout: 2'h0,
                  arm: 2'h0, runPrev: 2'h0, wbuf: DATA_RST, rbuf: DATA_RST,
                  sync1: 1'b0, sync2: 1'b0, inPrev: 1'b0};
      end else begin
         s_q <= s_d;
      end
   end

   assign upperVal = measMode ? s_q.dat[1] : s_q.cnt[1];
   assign lowerVal = buffered ? s_q.rbuf : lowerShow;
   assign bufFull  = s_q.bf[0];
   assign timerOut = s_q.tout;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   logic narrow;
   assign narrow = ~cascadeSel & ~varMode;

   property p_int_start;
      narrow && funcSel == MODE_INTERVAL && start0
         |=> s_q.lat[0] == $past(s_q.dat[0]) && s_q.cnt[0] == 8'h00;
   endproperty
   a_int_start: assert property (p_int_start) else $error("interval start");

   property p_int_reload;
      // a zero compare value legally holds the counter at zero, so it is left out
      narrow && funcSel == MODE_INTERVAL && runLo && !start0 &&
      s_q.cnt[0] == s_q.lat[0] && s_q.dat[0] != 8'h00
         |=> s_q.cnt[0] == 8'h00 ##1 (s_q.cnt[0] == 8'h01 || !runLo || start0);
   endproperty
   a_int_reload: assert property (p_int_reload) else $error("interval reload");

   property p_read_count;
      !measMode && !buffered |-> upperVal == s_q.cnt[1] && lowerVal == s_q.cnt[0];
   endproperty
   a_read_count: assert property (p_read_count) else $error("count read");

   property p_pwm_low;
      narrow && funcSel == MODE_PWM_FIX && runLo && !start0 &&
      s_q.cnt[0] == s_q.lat[0] && s_q.cnt[0] != 8'hff |=> !s_q.tout[0];
   endproperty
   a_pwm_low: assert property (p_pwm_low) else $error("pwm low");

   property p_pwm_wrap;
      narrow && funcSel == MODE_PWM_FIX && runLo && !start0 && s_q.cnt[0] == 8'hff
         |=> s_q.cnt[0] == 8'h00 && s_q.tout[0] && s_q.lat[0] == $past(s_q.dat[0]);
   endproperty
   a_pwm_wrap: assert property (p_pwm_wrap) else $error("pwm wrap");

   property p_var_start;
      varMode && start0 |=> !s_q.tout[0] && s_q.cnt == '0 && s_q.lat == $past(s_q.dat);
   endproperty
   a_var_start: assert property (p_var_start) else $error("var start");

   property p_var_period;
      varMode && runLo && !start0 && s_q.cnt[1] == s_q.lat[1]
         |=> s_q.cnt[1] == 8'h00 && !s_q.tout[0] && s_q.lat[1] == $past(s_q.dat[1]);
   endproperty
   a_var_period: assert property (p_var_period) else $error("var period");

   property p_pwc_hold;
      narrow && funcSel == MODE_PWC_HIGH && s_q.bf[0] && !rdLower && !wrLower
         |=> s_q.dat[0] == $past(s_q.dat[0]) && s_q.bf[0];
   endproperty
   a_pwc_hold: assert property (p_pwc_hold) else $error("pwc overwrite");

   property p_read_clear;
      narrow && funcSel == MODE_PWC_HIGH && rdLower && !(fall && runLo) |=> !s_q.bf[0];
   endproperty
   a_read_clear: assert property (p_read_clear) else $error("bf not cleared");

   property p_hc_high;
      narrow && funcSel == MODE_PWC_HC && runLo && !start0 && fall && !wrLower
         |=> s_q.bf[0] && s_q.dat[0] == $past(s_q.cnt[0]);
   endproperty
   a_hc_high: assert property (p_hc_high) else $error("high result lost");

   property p_capture;
      narrow && funcSel == MODE_CAPTURE && runLo && !start0 && rise && !wrLower
         |=> s_q.dat[0] == $past(s_q.cnt[0]);
   endproperty
   a_capture: assert property (p_capture) else $error("capture");

   property p_buf_read;
      buffered && rdUpper |=> s_q.rbuf == $past(lowerShow) ##1 !rdUpper |-> lowerVal == s_q.rbuf;
   endproperty
   a_buf_read: assert property (p_buf_read) else $error("read buffer");

   property p_buf_write;
      buffered && wrLower && !wrUpper
         |=> s_q.dat[1] == $past(s_q.wbuf) && s_q.dat[0] == $past(wrData);
   endproperty
   a_buf_write: assert property (p_buf_write) else $error("write buffer");

   property p_carry;
      wide && funcSel == MODE_CAPTURE && runLo && !start0 && s_q.cnt[0] == 8'hff
         |=> s_q.cnt[0] == 8'h00 && s_q.cnt[1] == $past(s_q.cnt[1]) + 8'h01;
   endproperty
   a_carry: assert property (p_carry) else $error("cascade carry");

   c_int_reload: cover property (narrow && funcSel == MODE_INTERVAL && runLo &&
                                 s_q.cnt[0] == s_q.lat[0]);
   c_pwc_full:   cover property (funcSel == MODE_PWC_HIGH && s_q.bf[0] && fall);
   c_var_period: cover property (varMode && runLo && s_q.cnt[1] == s_q.lat[1]);
   c_buf_pair:   cover property (buffered && rdUpper ##[1:8] rdLower);

endmodule

module ctd_top import ctd_pkg::*; (
   input  wire logic        sys_clk,  // system clock, 100 MHz
   input  wire logic        nrst,     // async reset, active low
   input  wire logic        psel,     // apb select
   input  wire logic        penable,  // apb enable
   input  wire logic        pwrite,   // apb direction, high for write
   input  wire logic [15:0] paddr,    // apb byte address
   input  wire logic [31:0] pwdata,   // apb write data
   output logic      [31:0] prdata,   // apb read data
   output logic             pready,   // apb ready
   output logic             pslverr,  // apb error on unmapped address
   input  wire logic  [1:0] measPin,  // measured input per channel
   output logic       [3:0] timerOut  // {ch1 upper, ch1 lower, ch0 upper, ch0 lower}
);

   typedef struct packed {
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
      logic [1:0][7:0] ctrl;
   } ctd_bus_t;

   ctd_bus_t        b_q;
   ctd_bus_t        b_d;
   logic            acc;
   logic [1:0]      rdUp;
   logic [1:0]      rdLo;
   logic [1:0]      wrUp;
   logic [1:0]      wrLo;
   logic [1:0]      ctrlHit;
   logic [1:0][7:0] upVal;
   logic [1:0][7:0] loVal;
   logic [1:0]      bfv;
   logic [1:0][7:0] ctrlRd;

   // a request is taken once, in the first access cycle
   assign acc = psel & penable & ~b_q.pready;

   always_comb begin
      b_d = b_q;
      b_d.pready = acc;
      b_d.pslverr = 1'b0;
      rdUp = '0;
      rdLo = '0;
      wrUp = '0;
      wrLo = '0;
      ctrlHit = '0;
      for (int c = 0; c < 2; c++) begin
         ctrlRd[c] = b_q.ctrl[c];
         ctrlRd[c][CTRL_BF] = bfv[c];
         rdUp[c] = acc & ~pwrite & (paddr == UPPER_ADDR[c]);
         rdLo[c] = acc & ~pwrite & (paddr == LOWER_ADDR[c]);
         wrUp[c] = acc & pwrite & (paddr == UPPER_ADDR[c]);
         wrLo[c] = acc & pwrite & (paddr == LOWER_ADDR[c]);
         ctrlHit[c] = acc & (paddr == CTRL_ADDR[c]);
         if (ctrlHit[c] && pwrite) begin
            b_d.ctrl[c] = pwdata[7:0];
            b_d.ctrl[c][CTRL_BF] = 1'b0;
            // cascade cannot change while either timer runs
            if (b_q.ctrl[c][CTRL_RUN_LO] || b_q.ctrl[c][CTRL_RUN_HI]) begin
               b_d.ctrl[c][CTRL_CASCADE] = b_q.ctrl[c][CTRL_CASCADE];
            end
         end
         if (rdUp[c]) begin
            b_d.prdata = {24'h000000, upVal[c]};
         end
         if (rdLo[c]) begin
            b_d.prdata = {24'h000000, loVal[c]};
         end
         if (ctrlHit[c] && !pwrite) begin
            b_d.prdata = {24'h000000, ctrlRd[c]};
         end
      end
      if (acc && (rdUp | rdLo | wrUp | wrLo | ctrlHit) == 2'h0) begin
         b_d.pslverr = 1'b1;
         b_d.prdata = 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         b_q <= '{pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
                  ctrl: {CTRL_RST, CTRL_RST}};
      end else begin
         b_q <= b_d;
      end
   end

   assign pready  = b_q.pready;
   assign pslverr = b_q.pslverr;
   assign prdata  = b_q.prdata;

   // ------------------------------------------------------------
   // two identical channels
   // ------------------------------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_chan
      ctd_channel u_chan (
         .sys_clk    (sys_clk),
         .nrst       (nrst),
         .runLo      (b_q.ctrl[c][CTRL_RUN_LO]),
         .runHi      (b_q.ctrl[c][CTRL_RUN_HI]),
         .cascadeSel (b_q.ctrl[c][CTRL_CASCADE]),
         .funcSel    (b_q.ctrl[c][CTRL_MODE_LO +: 4]),
         .measPin    (measPin[c]),
         .rdUpper    (rdUp[c]),
         .rdLower    (rdLo[c]),
         .wrUpper    (wrUp[c]),
         .wrLower    (wrLo[c]),
         .wrData     (pwdata[7:0]),
         .upperVal   (upVal[c]),
         .lowerVal   (loVal[c]),
         .bufFull    (bfv[c]),
         .timerOut   (timerOut[2*c+1:2*c])
      );
   end

endmodule

`default_nettype wire

// ===== shared/ctd_pkg.sv
// constants, codes and types shared by the composite timer data-register block
package ctd_pkg;

   // ------------------------------------------------------------
   // register indices; byte address is four times the index
   // ------------------------------------------------------------
   localparam logic [11:0] CH0_UPPER_IDX = 12'hf94;
   localparam logic [11:0] CH0_LOWER_IDX = 12'hf95;
   localparam logic [11:0] CH0_CTRL_IDX  = 12'hf96;
   localparam logic [11:0] CH1_UPPER_IDX = 12'hf99;
   localparam logic [11:0] CH1_LOWER_IDX = 12'hf9a;
   localparam logic [11:0] CH1_CTRL_IDX  = 12'hf9b;

   localparam logic [1:0][15:0] UPPER_ADDR = {{2'h0, CH1_UPPER_IDX, 2'h0},
                                              {2'h0, CH0_UPPER_IDX, 2'h0}};
   localparam logic [1:0][15:0] LOWER_ADDR = {{2'h0, CH1_LOWER_IDX, 2'h0},
                                              {2'h0, CH0_LOWER_IDX, 2'h0}};
   localparam logic [1:0][15:0] CTRL_ADDR  = {{2'h0, CH1_CTRL_IDX, 2'h0},
                                              {2'h0, CH0_CTRL_IDX, 2'h0}};

   // ------------------------------------------------------------
   // reset values and control field positions
   // ------------------------------------------------------------
   localparam logic [7:0] DATA_RST     = 8'h00;
   localparam logic [7:0] CTRL_RST     = 8'h00;
   localparam int         CTRL_RUN_LO  = 0;
   localparam int         CTRL_RUN_HI  = 1;
   localparam int         CTRL_CASCADE = 2;
   localparam int         CTRL_BF      = 3;
   localparam int         CTRL_MODE_LO = 4;

   // ------------------------------------------------------------
   // function select codes
   // ------------------------------------------------------------
   localparam logic [3:0] MODE_INTERVAL = 4'h0;
   localparam logic [3:0] MODE_PWM_FIX  = 4'h2;
   localparam logic [3:0] MODE_PWM_VAR  = 4'h3;
   localparam logic [3:0] MODE_PWC_HIGH = 4'h4;
   localparam logic [3:0] MODE_PWC_HC   = 4'h9;
   localparam logic [3:0] MODE_CAPTURE  = 4'ha;

   localparam logic [15:0] COUNT_TOP8  = 16'h00ff;
   localparam logic [15:0] COUNT_TOP16 = 16'hffff;

   typedef struct packed {
      logic [15:0] cnt;
      logic [15:0] lat;
      logic [15:0] dat;
      logic        bf;
      logic        out;
      logic        arm;
   } ctd_unit_t;

endpackage

// ===== testbench/ctd_pulse_src.sv
// model of the external pulse source feeding one measured input pin
`timescale 1ns/10ps
`default_nettype none

module ctd_pulse_src (
   input  wire logic       sys_clk, // system clock
   input  wire logic       nrst,    // async reset, active low
   input  wire logic       go,      // start one high pulse
   input  wire logic [7:0] len,     // pulse width in clocks
   output logic            pin      // pulse output, idles low
);
   logic [7:0] left_q;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         left_q <= 8'h00;
      end else if (go) begin
         left_q <= len;
      end else if (left_q != 8'h00) begin
         left_q <= left_q - 8'h01;
      end
   end

   assign pin = (left_q != 8'h00);
endmodule

`default_nettype wire

// ===== testbench/ctd_top_tb.sv
// self-checking testbench for the composite timer data-register block
`timescale 1ns/10ps
`default_nettype none

module ctd_top_tb import ctd_pkg::*;;
   logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0]  measPin, go;
   logic [3:0]  timerOut;
   logic [7:0]  len, v;
   logic [15:0] hi;
   int          num_errors, n_compared;

   ctd_top dut (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .measPin(measPin), .timerOut(timerOut));
   ctd_pulse_src src0 (.sys_clk(sys_clk), .nrst(nrst), .go(go[0]), .len(len), .pin(measPin[0]));
   ctd_pulse_src src1 (.sys_clk(sys_clk), .nrst(nrst), .go(go[1]), .len(len), .pin(measPin[1]));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic wrap_up();
      if (num_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("FAIL %s exp %h got %h", nm, exp, got);
         num_errors++;
      end
   endtask

   // one apb transfer; request held until pready is sampled high
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= {24'h000000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      v = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge keeps the next call from reassigning psel in this time step
      @(posedge sys_clk);
      if (k >= 50) begin
         num_errors++;
         wrap_up();
      end
   endtask

   task automatic pulse(input int c, input logic [7:0] n);
      len <= n;
      go  <= (c == 0) ? 2'h1 : 2'h2;
      @(posedge sys_clk);
      go  <= 2'h0;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 16'h0000;
      pwdata = 32'h00000000; go = 2'h0; len = 8'h00; num_errors = 0; n_compared = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1'b1;
      for (int c = 0; c < 2; c++) begin
         xfer(1'b0, UPPER_ADDR[c], 8'h00); chk("upper rst", {8'h00, v}, {8'h00, DATA_RST});
         xfer(1'b0, LOWER_ADDR[c], 8'h00); chk("lower rst", {8'h00, v}, {8'h00, DATA_RST});
      end
      xfer(1'b0, 16'h0000, 8'h00);
      chk("unmapped", {15'h0000, err}, 16'h0001);
      // interval: reads see the counter, which never passes the compare value
      xfer(1'b1, LOWER_ADDR[0], 8'h05);
      xfer(1'b1, CTRL_ADDR[0], 8'h01);
      for (int i = 0; i < 12; i++) begin
         xfer(1'b0, LOWER_ADDR[0], 8'h00); chk("interval cnt", {15'h0000, v <= 8'h05}, 16'h0001);
      end
      xfer(1'b1, CTRL_ADDR[0], 8'h00);
      // fixed pwm: high for compare+1 clocks of each 256-clock cycle
      xfer(1'b1, LOWER_ADDR[0], 8'h80);
      xfer(1'b1, CTRL_ADDR[0], 8'h21);
      repeat (300) @(posedge sys_clk);
      hi = 16'h0000;
      repeat (512) begin
         @(posedge sys_clk);
         hi = hi + {15'h0000, timerOut[0]};
      end
      chk("pwm duty", {15'h0000, hi >= 16'h00fe && hi <= 16'h0106}, 16'h0001);
      xfer(1'b1, CTRL_ADDR[0], 8'h00);
      // high-pulse measure on channel 1; second result blocked while full
      xfer(1'b1, CTRL_ADDR[1], 8'h41);
      pulse(1, 8'h14);
      repeat (40) @(posedge sys_clk);
      xfer(1'b0, CTRL_ADDR[1], 8'h00); chk("full set", {15'h0000, v[CTRL_BF]}, 16'h0001);
      pulse(1, 8'h3c);
      repeat (80) @(posedge sys_clk);
      xfer(1'b0, LOWER_ADDR[1], 8'h00);
      chk("width kept", {15'h0000, v >= 8'h11 && v <= 8'h17}, 16'h0001);
      xfer(1'b0, CTRL_ADDR[1], 8'h00); chk("full clr", {15'h0000, v[CTRL_BF]}, 16'h0000);
      xfer(1'b1, LOWER_ADDR[1], 8'h5a);
      xfer(1'b0, LOWER_ADDR[1], 8'h00); chk("overwrite", {8'h00, v}, 16'h005a);
      // 16-bit buffered access, timer stopped in capture mode
      xfer(1'b1, CTRL_ADDR[0], 8'ha4);
      xfer(1'b1, UPPER_ADDR[0], 8'h12);
      xfer(1'b0, UPPER_ADDR[0], 8'h00); chk("upper held", {8'h00, v}, 16'h0000);
      xfer(1'b1, LOWER_ADDR[0], 8'h34);
      xfer(1'b0, UPPER_ADDR[0], 8'h00); chk("upper commit", {8'h00, v}, 16'h0012);
      xfer(1'b0, LOWER_ADDR[0], 8'h00); chk("lower buffer", {8'h00, v}, 16'h0034);
      // capture, cascaded and running long enough for the lower byte to carry
      xfer(1'b1, CTRL_ADDR[0], 8'ha5);
      repeat (300) @(posedge sys_clk);
      pulse(0, 8'h04);
      repeat (20) @(posedge sys_clk);
      xfer(1'b0, UPPER_ADDR[0], 8'h00);
      hi = {v, 8'h00};
      xfer(1'b0, LOWER_ADDR[0], 8'h00);
      hi[7:0] = v;
      chk("capture", {15'h0000, hi >= 16'h0128 && hi <= 16'h0138}, 16'h0001);
      // high plus cycle on channel 1: the second high result replaces the first
      xfer(1'b1, CTRL_ADDR[1], 8'h91);
      pulse(1, 8'h14);
      repeat (40) @(posedge sys_clk);
      pulse(1, 8'h0a);
      repeat (40) @(posedge sys_clk);
      xfer(1'b0, LOWER_ADDR[1], 8'h00);
      chk("high kept", {15'h0000, v >= 8'h07 && v <= 8'h0b}, 16'h0001);
      // variable pwm on channel 1: low for lower+1 clocks of each upper+1 clocks
      xfer(1'b1, CTRL_ADDR[1], 8'h30);
      xfer(1'b1, UPPER_ADDR[1], 8'h09);
      xfer(1'b1, LOWER_ADDR[1], 8'h03);
      xfer(1'b1, CTRL_ADDR[1], 8'h31);
      repeat (50) @(posedge sys_clk);
      hi = 16'h0000;
      repeat (100) begin
         @(posedge sys_clk);
         hi = hi + {15'h0000, timerOut[2]};
      end
      chk("var duty", {15'h0000, hi >= 16'h003a && hi <= 16'h003e}, 16'h0001);
      wrap_up();
   end
endmodule

`default_nettype wire
